// File: pkg/rcp_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RCP_DEFS_SVH
`define RCP_DEFS_SVH
`define RCP_ADDR_PRS     3'h0
`define RCP_ADDR_IST     3'h1
`define RCP_ADDR_IMSK    3'h2
`define RCP_ADDR_CFG     3'h3
`define RCP_ADDR_STAT    3'h4
`define RCP_ADDR_IN_CIRCUIT_SERIAL_PROGRAMMING    3'h5
`define RCP_PRS_BOR_BIT  0
`define RCP_PRS_POR_BIT  1
`define RCP_PRS_RST      2'h0
`define RCP_LVP_RST      1'h1
`define RCP_EV_POR       0
`define RCP_EV_BOR       1
`define RCP_EV_WAKE      2
`define RCP_EV_PROG      3
`define RCP_CLK_KHZ      40000
`define RCP_POWERUP_DELAY_TIMER_MS      72
`define RCP_OST_TOSC     1024
`define RCP_POWERUP_DELAY_TIMER_CYC     (`RCP_POWERUP_DELAY_TIMER_MS * `RCP_CLK_KHZ)
`endif

// File: pkg/rcp_pkg.sv
// Types shared by the reset sequencer files
package rcp_pkg;
  typedef enum logic [2:0] {
    RCP_ST_RUN  = 3'h0,
    RCP_ST_HOLD = 3'h1,
    RCP_ST_POWERUP_DELAY_TIMER = 3'h2,
    RCP_ST_OST  = 3'h3,
    RCP_ST_PROG = 3'h4
  } rcp_state_t;
  typedef enum logic [1:0] {
    RCP_CS_POR  = 2'h0,
    RCP_CS_BOR  = 2'h1,
    RCP_CS_WAKE = 2'h2,
    RCP_CS_MASTER_CLEAR_PIN = 2'h3
  } rcp_cause_t;
  typedef enum logic [1:0] {
    RCP_OSC_LP = 2'h0,
    RCP_OSC_XT = 2'h1,
    RCP_OSC_HS = 2'h2,
    RCP_OSC_RC = 2'h3
  } rcp_osc_t;
endpackage : rcp_pkg

// File: logic/rcp_sync2.sv
// Two flip-flop synchroniser for pin inputs
module rcp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : rcp_sync2

// File: logic/rcp_reset_seq.sv
// Reset cause flags, reset time-out sequencer and programming entry
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`include "rcp_defs.svh"
module rcp_reset_seq
  import rcp_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_CYC = `RCP_POWERUP_DELAY_TIMER_CYC,
  parameter int OST_CYC  = `RCP_OST_TOSC,
  parameter int CNT_W    = 22
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  output logic            irq_o,
  input  wire logic       por_det_i,
  input  wire logic       bor_det_i,
  input  wire logic       wake_i,
  input  wire logic       master_clear_pin_n_i,
  input  wire logic       programming_high_voltage_i,
  input  wire logic       program_entry_pin_i,
  input  wire logic [1:0] osc_mode_i,
  input  wire logic       powerup_timer_enable_n_i,
  input  wire logic       brownout_enable_i,
  input  wire logic       in_circuit_serial_programming_clk_i,
  input  wire logic       in_circuit_serial_programming_data_i,
  output logic            in_circuit_serial_programming_data_o,
  output logic            in_circuit_serial_programming_data_oe_n_o,
  output logic            dev_reset_o,
  output logic            program_mode_o,
  output logic            pin_gpio_en_o
);
  localparam logic [CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = CNT_W'(POWERUP_DELAY_TIMER_CYC - 1);
  localparam logic [CNT_W-1:0] OST_LAST  = CNT_W'(OST_CYC - 1);

  function automatic logic rcp_is_crystal(input logic [1:0] m);
    return m != RCP_OSC_RC;
  endfunction : rcp_is_crystal

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [6:0] pins_s;
  logic       por_s;
  logic       bor_s;
  logic       master_clear_pin_n_s;
  logic       hv_s;
  logic       pgm_s;
  logic       sclk_s;
  logic       sdat_s;

  rcp_sync2 #(.W(7)) u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .d_i       ({por_det_i, bor_det_i, master_clear_pin_n_i,
                 programming_high_voltage_i, program_entry_pin_i,
                 in_circuit_serial_programming_clk_i, in_circuit_serial_programming_data_i}),
    .q_o       (pins_s)
  );
  assign {por_s, bor_s, master_clear_pin_n_s, hv_s, pgm_s, sclk_s, sdat_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // State
  rcp_state_t       state_r;
  rcp_state_t       state_nxt;
  rcp_cause_t       cause_r;
  rcp_cause_t       cause_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             por_q_r;
  logic             sclk_q_r;
  logic             hv_session_r;
  logic             lvp_r;
  logic [1:0]       prs_r;
  logic [3:0]       ist_r;
  logic [3:0]       imsk_r;
  logic [7:0]       in_circuit_serial_programming_shift_r;

  wire por_rise   = por_s && !por_q_r;
  wire crystal    = rcp_is_crystal(osc_mode_i);
  wire hv_entry   = hv_s;
  wire lv_entry   = lvp_r && pgm_s && master_clear_pin_n_s;
  wire prog_req   = hv_entry || lv_entry;
  // Brown-out always runs the timer; power-on only when the timer or brown-out is enabled
  wire powerup_delay_timer_on    = (cause_r == RCP_CS_BOR) ||
                    (cause_r == RCP_CS_POR &&
                     (!powerup_timer_enable_n_i || brownout_enable_i));
  wire powerup_delay_timer_done  = cnt_r == POWERUP_DELAY_TIMER_LAST;
  wire ost_done   = cnt_r == OST_LAST;
  wire ost_on     = crystal && (cause_r != RCP_CS_MASTER_CLEAR_PIN);

  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    cnt_nxt   = cnt_r + CNT_W'(1);
    case (state_r)
      RCP_ST_HOLD: begin
        cnt_nxt = '0;
        if (!bor_s) begin
          if (powerup_delay_timer_on) state_nxt = RCP_ST_POWERUP_DELAY_TIMER;
          else if (ost_on) state_nxt = RCP_ST_OST;
          else state_nxt = RCP_ST_RUN;
        end
      end
      RCP_ST_POWERUP_DELAY_TIMER: begin
        if (powerup_delay_timer_done) begin
          cnt_nxt   = '0;
          state_nxt = crystal ? RCP_ST_OST : RCP_ST_RUN;
        end
      end
      RCP_ST_OST: begin
        if (ost_done) state_nxt = RCP_ST_RUN;
      end
      RCP_ST_PROG: begin
        cnt_nxt = '0;
        if (!prog_req) begin
          state_nxt = RCP_ST_HOLD;
          cause_nxt = RCP_CS_MASTER_CLEAR_PIN;
        end
      end
      RCP_ST_RUN: begin
        cnt_nxt = '0;
        if (wake_i && crystal) begin
          state_nxt = RCP_ST_OST;
          cause_nxt = RCP_CS_WAKE;
        end
      end
      default: begin
        state_nxt = RCP_ST_HOLD;
        cnt_nxt   = '0;
      end
    endcase
    // Power-on and enabled brown-out restart the sequence from any state; a programming request wins over both
    if (bor_s && brownout_enable_i) begin
      state_nxt = RCP_ST_HOLD;
      cause_nxt = RCP_CS_BOR;
      cnt_nxt   = '0;
    end
    if (por_rise) begin
      state_nxt = RCP_ST_HOLD;
      cause_nxt = RCP_CS_POR;
      cnt_nxt   = '0;
    end
    if (prog_req) begin
      state_nxt = RCP_ST_PROG;
      cnt_nxt   = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_r  <= RCP_ST_HOLD;
      cause_r  <= RCP_CS_POR;
      cnt_r    <= '0;
      por_q_r  <= 1'b0;
      sclk_q_r <= 1'b0;
    end else if (ce_i) begin
      state_r  <= state_nxt;
      cause_r  <= cause_nxt;
      cnt_r    <= cnt_nxt;
      por_q_r  <= por_s;
      sclk_q_r <= sclk_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  wire wr_prs  = wr_i && addr_i == `RCP_ADDR_PRS;
  wire wr_ist  = wr_i && addr_i == `RCP_ADDR_IST;
  wire wr_imsk = wr_i && addr_i == `RCP_ADDR_IMSK;
  wire wr_cfg  = wr_i && addr_i == `RCP_ADDR_CFG;
  wire bor_hit = bor_s && brownout_enable_i;
  wire enter_prog = prog_req && state_r != RCP_ST_PROG;
  wire [3:0] events = {enter_prog, wake_i && state_r == RCP_ST_RUN, bor_hit, por_rise};

  // Hardware clears beat a software write in the same cycle
  wire [1:0] prs_nxt = {
    por_rise ? 1'b0 : (wr_prs ? wr_data_i[`RCP_PRS_POR_BIT] : prs_r[1]),
    bor_hit  ? 1'b0 : (wr_prs ? wr_data_i[`RCP_PRS_BOR_BIT] : prs_r[0])
  };
  wire [3:0] ist_nxt = (ist_r & ~(wr_ist ? wr_data_i[3:0] : 4'h0)) | events;
  // Config write lands only during a high-voltage session
  wire       lvp_nxt = (wr_cfg && hv_session_r) ? wr_data_i[0] : lvp_r;
  wire       hv_nxt  = (state_nxt == RCP_ST_PROG) &&
                       (hv_session_r || (enter_prog && hv_entry));
  wire       reset_nxt = state_nxt != RCP_ST_RUN || !master_clear_pin_n_s;
  wire [7:0] rd_mux =
    (addr_i == `RCP_ADDR_PRS)  ? {6'h00, prs_r} :
    (addr_i == `RCP_ADDR_IST)  ? {4'h0, ist_r} :
    (addr_i == `RCP_ADDR_IMSK) ? {4'h0, imsk_r} :
    (addr_i == `RCP_ADDR_CFG)  ? {7'h00, lvp_r} :
    (addr_i == `RCP_ADDR_STAT) ? {3'h0, hv_session_r, dev_reset_o, state_r} :
    (addr_i == `RCP_ADDR_IN_CIRCUIT_SERIAL_PROGRAMMING) ? in_circuit_serial_programming_shift_r : 8'h00;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prs_r        <= `RCP_PRS_RST;
      ist_r        <= 4'h0;
      imsk_r       <= 4'h0;
      lvp_r        <= `RCP_LVP_RST;
      hv_session_r <= 1'b0;
      rd_data_o    <= 8'h00;
      irq_o        <= 1'b0;
    end else if (ce_i) begin
      prs_r        <= prs_nxt;
      ist_r        <= ist_nxt;
      imsk_r       <= wr_imsk ? wr_data_i[3:0] : imsk_r;
      lvp_r        <= lvp_nxt;
      hv_session_r <= hv_nxt;
      rd_data_o    <= rd_i ? rd_mux : 8'h00;
      irq_o        <= |(ist_nxt & imsk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and serial capture
  // Only the capture side of the serial link lives here; the data line is
  // released and the command protocol belongs to the programming engine.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dev_reset_o      <= 1'b1;
      program_mode_o   <= 1'b0;
      pin_gpio_en_o    <= 1'b0;
      in_circuit_serial_programming_shift_r     <= 8'h00;
      in_circuit_serial_programming_data_o      <= 1'b0;
      in_circuit_serial_programming_data_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      dev_reset_o      <= reset_nxt;
      program_mode_o   <= state_nxt == RCP_ST_PROG;
      pin_gpio_en_o    <= !lvp_nxt;
      if (state_r == RCP_ST_PROG && sclk_s && !sclk_q_r) begin
        in_circuit_serial_programming_shift_r <= {in_circuit_serial_programming_shift_r[6:0], sdat_s};
      end
      in_circuit_serial_programming_data_o      <= 1'b0;
      in_circuit_serial_programming_data_oe_n_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_status_rsvd_zero: assert property (
    ce_i && rd_i && addr_i == `RCP_ADDR_PRS |=> rd_data_o[7:2] == 6'h00)
    else $error("status reserved bits not zero");
  a_por_flag_clear: assert property (
    ce_i && por_rise |=> !prs_r[`RCP_PRS_POR_BIT])
    else $error("power-on flag not cleared");
  a_bor_flag_clear: assert property (
    ce_i && bor_hit |=> !prs_r[`RCP_PRS_BOR_BIT])
    else $error("brown-out flag not cleared");
  a_por_flag_keep: assert property (
    ce_i && !por_rise && !wr_prs |=> $stable(prs_r[`RCP_PRS_POR_BIT]))
    else $error("power-on flag changed without cause");
  a_pin_dedicated: assert property (
    ce_i && lvp_r ##1 ce_i && lvp_r |-> !pin_gpio_en_o)
    else $error("pin still general purpose");
  a_hv_entry: assert property (
    ce_i && hv_s |=> state_r == RCP_ST_PROG && program_mode_o)
    else $error("high voltage did not enter programming");
  a_lv_entry: assert property (
    ce_i && lvp_r && pgm_s && master_clear_pin_n_s |=> state_r == RCP_ST_PROG)
    else $error("pin entry ignored while enabled");
  a_lv_blocked: assert property (
    ce_i && !lvp_r && !hv_s && state_r != RCP_ST_PROG |=> state_r != RCP_ST_PROG)
    else $error("entry without high voltage while disabled");
  a_cfg_locked: assert property (
    ce_i && wr_cfg && !hv_session_r |=> $stable(lvp_r))
    else $error("enable bit changed outside session");
  a_lvp_default: assert property (
    $past(sys_rst_i) |-> lvp_r)
    else $error("enable bit not one after reset");
  a_ost_length: assert property (
    ce_i && state_r == RCP_ST_OST && state_nxt == RCP_ST_RUN |-> cnt_r == OST_LAST)
    else $error("start-up count wrong length");
  a_powerup_delay_timer_forced: assert property (
    ce_i && state_r == RCP_ST_HOLD && cause_r == RCP_CS_POR && brownout_enable_i &&
    !bor_s && !por_rise && !prog_req |=> state_r == RCP_ST_POWERUP_DELAY_TIMER)
    else $error("power-up timer skipped with brown-out enabled");
  a_rc_no_ost: assert property (
    ce_i && state_r == RCP_ST_POWERUP_DELAY_TIMER && powerup_delay_timer_done && !crystal && !bor_hit && !por_rise &&
    !prog_req |=> state_r == RCP_ST_RUN)
    else $error("resistor mode ran start-up count");

  c_enter_prog: cover property (ce_i && enter_prog ##1 program_mode_o);
  c_ost_to_run: cover property (state_r == RCP_ST_OST ##1 state_r == RCP_ST_RUN);
  c_powerup_delay_timer_to_ost: cover property (state_r == RCP_ST_POWERUP_DELAY_TIMER ##1 state_r == RCP_ST_OST);
  c_irq_rise: cover property ($rose(irq_o));
endmodule : rcp_reset_seq

// File: testbench/rcp_prog_model.sv
// Model of the external programmer and supply monitor on the device pins
module rcp_prog_model (
  input  wire logic clock_i,
  output logic      por_det_o,
  output logic      bor_det_o,
  output logic      master_clear_pin_n_o,
  output logic      programming_high_voltage_o,
  output logic      program_entry_pin_o,
  output logic      in_circuit_serial_programming_clk_o,
  output logic      in_circuit_serial_programming_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    por_det_o                  = 1'h0;
    bor_det_o                  = 1'h0;
    master_clear_pin_n_o       = 1'h1;
    programming_high_voltage_o = 1'h0;
    program_entry_pin_o        = 1'h0; // Board pull-down, port pull-up off
    in_circuit_serial_programming_clk_o                 = 1'h0; // Serial clock stands still outside frames
    in_circuit_serial_programming_data_o                = 1'h0; // Only clock and data lines are used
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Supply event held for n cycles: brown-out when bo is set, else power-on
  task automatic supply(input logic bo, input int n);
    @(posedge clock_i);
    if (bo) bor_det_o <= 1'h1;
    else por_det_o <= 1'h1;
    repeat (n) @(posedge clock_i);
    bor_det_o <= 1'h0;
    por_det_o <= 1'h0;
  endtask : supply
  // Clear stays at the supply level while the entry pin is raised
  task automatic lv_entry(input logic on);
    @(posedge clock_i);
    master_clear_pin_n_o <= 1'h1;
    program_entry_pin_o  <= on;
  endtask : lv_entry
  task automatic hv_entry(input logic on);
    @(posedge clock_i);
    programming_high_voltage_o <= on;
  endtask : hv_entry
  task automatic clear_pin(input logic lvl);
    @(posedge clock_i);
    master_clear_pin_n_o <= lvl;
  endtask : clear_pin
  // Oldest bit first; data settles three cycles before each clock rise
  task automatic shift_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock_i);
      in_circuit_serial_programming_data_o <= b[i];
      repeat (3) @(posedge clock_i);
      in_circuit_serial_programming_clk_o <= 1'h1;
      repeat (3) @(posedge clock_i);
      in_circuit_serial_programming_clk_o <= 1'h0;
    end
  endtask : shift_byte
endmodule : rcp_prog_model

// File: testbench/reset_cause_and_program_entry_tb_top.sv
// Self-checking bench for the reset cause and programming entry block
`include "rcp_defs.svh"
module reset_cause_and_program_entry_tb_top;
  import rcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 20;
  localparam int OS = 8;
  logic clock_i = 1'h0, sys_rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, wake_i = 1'h0;
  logic tmr_n = 1'h0, bo_en = 1'h1, irq_o, dev_reset_o, program_mode_o, pin_gpio_en_o;
  logic ce = 1'h1;
  logic por, bor, master_clear_pin_n, hv, pgm, sclk, sdat, in_circuit_serial_programming_data_o, in_circuit_serial_programming_data_oe_n_o;
  logic [1:0] osc = RCP_OSC_XT;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wr_data_i = 8'h00, rd_data_o;
  int error_cnt = 0, n_compared = 0;
  always #12.5 clock_i = ~clock_i;
  rcp_prog_model u_prog (.clock_i(clock_i), .por_det_o(por), .bor_det_o(bor),
    .master_clear_pin_n_o(master_clear_pin_n), .programming_high_voltage_o(hv),
    .program_entry_pin_o(pgm), .in_circuit_serial_programming_clk_o(sclk), .in_circuit_serial_programming_data_o(sdat));
  rcp_reset_seq #(.POWERUP_DELAY_TIMER_CYC(PW), .OST_CYC(OS)) u_dut (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .ce_i(ce), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o), .por_det_i(por),
    .bor_det_i(bor), .wake_i(wake_i), .master_clear_pin_n_i(master_clear_pin_n),
    .programming_high_voltage_i(hv), .program_entry_pin_i(pgm), .osc_mode_i(osc),
    .powerup_timer_enable_n_i(tmr_n), .brownout_enable_i(bo_en), .in_circuit_serial_programming_clk_i(sclk),
    .in_circuit_serial_programming_data_i(sdat), .in_circuit_serial_programming_data_o(in_circuit_serial_programming_data_o), .in_circuit_serial_programming_data_oe_n_o(in_circuit_serial_programming_data_oe_n_o),
    .dev_reset_o(dev_reset_o), .program_mode_o(program_mode_o),
    .pin_gpio_en_o(pin_gpio_en_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic fail(input string m);
    $display("unexpected %0t %s", $time, m);
    error_cnt++;
  endtask : fail
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask : chk8
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string m);
    @(posedge clock_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1 chk8(rd_data_o, e, m);
  endtask : rchk
  // Waits for reset to be taken, then counts cycles until the device runs
  task automatic run_in(input int lo, input int hi, input string m);
    int n;
    // Step off the edge so a reset launched at this edge is already visible
    #1 n = 0;
    while (dev_reset_o !== 1'h1 && n < 8) begin
      @(posedge clock_i);
      #1 n++;
    end
    if (n >= 8) fail(m);
    n = 0;
    while (dev_reset_o !== 1'h0 && n < 3000) begin
      @(posedge clock_i);
      #1 n++;
    end
    n_compared++;
    if (n < lo || n > hi) fail(m);
    if (n >= 3000) stop_test();
  endtask : run_in
  task automatic wait_pm(input logic e, input string m);
    int n;
    n = 0;
    while (program_mode_o !== e && n < 16) begin
      @(posedge clock_i);
      #1 n++;
    end
    chk8({7'h0, program_mode_o}, {7'h0, e}, m);
    if (n >= 16) stop_test();
  endtask : wait_pm
  // Device must stay running with no programming entry for n cycles
  task automatic stay_run(input int n, input string m);
    logic bad;
    bad = 1'h0;
    repeat (n) begin
      @(posedge clock_i);
      #1 bad = bad | (dev_reset_o !== 1'h0) | (program_mode_o !== 1'h0);
    end
    chk8({7'h0, bad}, 8'h00, m);
  endtask : stay_run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk8({5'h0, dev_reset_o, in_circuit_serial_programming_data_oe_n_o, pin_gpio_en_o}, 8'h06, "pins");
    run_in(PW + OS, PW + OS + 4, "power-up time");
    rchk(`RCP_ADDR_PRS, 8'h00, "status reset");
    rchk(`RCP_ADDR_CFG, 8'h01, "entry enable");
    wr(`RCP_ADDR_PRS, 8'hFF);
    rchk(`RCP_ADDR_PRS, 8'h03, "status bits");
  endtask : t_reset
  task automatic t_brownout();
    wr(`RCP_ADDR_IST, 8'hFF);
    wr(`RCP_ADDR_IMSK, 8'h02);
    u_prog.supply(1'h1, 4);
    run_in(PW + OS, PW + OS + 8, "brown-out time");
    rchk(`RCP_ADDR_PRS, 8'h02, "brown-out flag");
    chk8({7'h0, irq_o}, 8'h01, "irq raise");
    wr(`RCP_ADDR_IST, 8'h02);
    @(posedge clock_i);
    #1 chk8({7'h0, irq_o}, 8'h00, "irq clear");
  endtask : t_brownout
  task automatic t_por_rc();
    wr(`RCP_ADDR_PRS, 8'h03);
    osc <= RCP_OSC_RC;
    tmr_n <= 1'h1;
    u_prog.supply(1'h0, 4);
    run_in(PW, PW + 8, "rc power-up time");
    rchk(`RCP_ADDR_PRS, 8'h01, "power-on flag");
    rchk(`RCP_ADDR_IST, 8'h01, "power-on event");
    wr(`RCP_ADDR_IST, 8'hFF);
  endtask : t_por_rc
  task automatic t_wake();
    @(posedge clock_i);
    wake_i <= 1'h1;
    @(posedge clock_i);
    wake_i <= 1'h0;
    stay_run(12, "rc wake");
    rchk(`RCP_ADDR_IST, 8'h04, "wake status");
    chk8({7'h0, irq_o}, 8'h00, "masked irq");
    osc <= RCP_OSC_XT;
    @(posedge clock_i);
    wake_i <= 1'h1;
    @(posedge clock_i);
    wake_i <= 1'h0;
    run_in(OS, OS + 4, "crystal wake time");
  endtask : t_wake
  task automatic t_freeze();
    @(posedge clock_i);
    ce <= 1'h0;
    wr(`RCP_ADDR_IMSK, 8'h0F);
    ce <= 1'h1;
    rchk(`RCP_ADDR_IMSK, 8'h02, "frozen write");
  endtask : t_freeze
  task automatic t_bor_off();
    bo_en <= 1'h0;
    u_prog.supply(1'h1, 4);
    stay_run(8, "brown-out ignored");
    rchk(`RCP_ADDR_IST, 8'h04, "no brown-out event");
    bo_en <= 1'h1;
  endtask : t_bor_off
  task automatic t_clear();
    u_prog.clear_pin(1'h0);
    repeat (6) @(posedge clock_i);
    #1 chk8({7'h0, dev_reset_o}, 8'h01, "clear holds reset");
    u_prog.clear_pin(1'h1);
    run_in(2, 4, "clear release");
  endtask : t_clear
  task automatic t_entry();
    wr(`RCP_ADDR_CFG, 8'h00);
    rchk(`RCP_ADDR_CFG, 8'h01, "cfg locked");
    u_prog.lv_entry(1'h1);
    wait_pm(1'h1, "lv entry");
    chk8({7'h0, pin_gpio_en_o}, 8'h00, "pin dedicated");
    u_prog.lv_entry(1'h0);
    run_in(0, PW + OS + 8, "lv exit");
    u_prog.hv_entry(1'h1);
    wait_pm(1'h1, "hv entry");
    rchk(`RCP_ADDR_STAT, 8'h1C, "hv session");
    u_prog.shift_byte(8'hA5);
    rchk(`RCP_ADDR_IN_CIRCUIT_SERIAL_PROGRAMMING, 8'hA5, "serial capture");
    wr(`RCP_ADDR_CFG, 8'h00);
    @(posedge clock_i);
    #1 chk8({7'h0, pin_gpio_en_o}, 8'h01, "pin to gpio");
    u_prog.hv_entry(1'h0);
    run_in(0, PW + OS + 8, "hv exit");
    u_prog.lv_entry(1'h1);
    stay_run(12, "pin ignored");
    u_prog.lv_entry(1'h0);
  endtask : t_entry
  initial begin
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    @(posedge clock_i);
    #1 t_reset();
    t_brownout();
    t_por_rc();
    t_wake();
    t_freeze();
    t_bor_off();
    t_clear();
    t_entry();
    stop_test();
  end
endmodule : reset_cause_and_program_entry_tb_top
